// ==== src/lpsup_core.sv ====
`timescale 1ns/100ps
// Summary of operation
// - heartbeat 1200 ns after transmit, 1000 ns long
// - jabber on after 85 ms, off 500 ms
// - idle normal link pulse 100 ns, 16 ms
// - burst clock and data pulses 100 ns wide
// - burst clock pulses 125 us apart
// - one bit gives data pulse 62 us later
// - burst spans 2 ms first to last
// - bursts start 16 ms apart
module lpsup_core #(
    parameter int JAB_ON    = lpsup_pkg::JAB_ON_CYC,
    parameter int JAB_OFF   = lpsup_pkg::JAB_OFF_CYC,
    parameter int PERIOD    = lpsup_pkg::PERIOD_CYC,
    parameter int CLK_SPACE = lpsup_pkg::CLK_SPACE_CYC,
    parameter int DATA_OFS  = lpsup_pkg::DATA_OFS_CYC
) (
    // clock and reset
    input  wire logic                     core_clk,
    input  wire logic                     reset_n,
    // mode and transmit
    input  wire lpsup_pkg::lpsup_mode_type link_mode,
    input  wire logic                     mode_10m,
    input  wire logic                     tx_active,
    input  wire logic [lpsup_pkg::WORD_BITS-1:0] burst_word,
    // outputs
    output lpsup_pkg::lpsup_link_type     link_out,
    output logic                          collision_heartbeat,
    output logic                          jabber_active,
    output logic                          tx_gated
);
    import lpsup_pkg::*;

    // slot index spans every clock pulse of a burst; the width counter spans one pulse
    localparam int IDX_W = $clog2(BURST_CLOCKS + 1);
    localparam int PW_W  = $clog2(PULSE_CYC + 1);

    // true in the closing clock slot, which never carries a data pulse
    function automatic logic last_slot(input logic [IDX_W-1:0] slot);
        return slot == IDX_W'(BURST_CLOCKS - 1);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // heartbeat after end of transmission
    // a new end of transmit restarts the timer; mode_10m is looked at on that edge only
    logic             tx_prev_q;
    logic [CNT_W-1:0] hb_cnt_q;
    logic             hb_run_q;
    logic             tx_end;
    // end of transmit in 10 Mb/s arms the heartbeat
    assign tx_end = tx_prev_q && !tx_active && mode_10m;

    // counter runs from the end of transmit through the end of the pulse
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_prev_q           <= 1'b0;
            hb_cnt_q            <= '0;
            hb_run_q            <= 1'b0;
            collision_heartbeat <= 1'b0;
        end else begin
            tx_prev_q <= tx_active;
            if (tx_end) begin
                hb_run_q            <= 1'b1;
                hb_cnt_q            <= '0;
                collision_heartbeat <= 1'b0;
            end else if (hb_run_q) begin
                hb_cnt_q <= hb_cnt_q + 1'b1;
                // rises after the delay count, falls after the width count
                if (hb_cnt_q == CNT_W'(HB_DELAY_CYC - 1)) begin
                    collision_heartbeat <= 1'b1;
                end
                if (hb_cnt_q == CNT_W'(HB_DELAY_CYC + HB_WIDTH_CYC - 1)) begin
                    collision_heartbeat <= 1'b0;
                    hb_run_q            <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // jabber supervisor
    // counts continuous 10 Mb/s transmit; the release timer then ignores transmit
    logic [CNT_W-1:0] jab_cnt_q;

    // one counter serves both the arming and the release time
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            jab_cnt_q     <= '0;
            jabber_active <= 1'b0;
        end else if (!jabber_active) begin
            // arming: only an unbroken run of 10 Mb/s transmit counts
            if (tx_active && mode_10m) begin
                if (jab_cnt_q == CNT_W'(JAB_ON - 1)) begin
                    jabber_active <= 1'b1;
                    jab_cnt_q     <= '0;
                end else begin
                    jab_cnt_q <= jab_cnt_q + 1'b1;
                end
            end else begin
                jab_cnt_q <= '0;
            end
        end else begin
            if (jab_cnt_q == CNT_W'(JAB_OFF - 1)) begin
                jabber_active <= 1'b0;
                jab_cnt_q     <= '0;
            end else begin
                jab_cnt_q <= jab_cnt_q + 1'b1;
            end
        end
    end

    // transmit passes only while the supervisor is quiet
    assign tx_gated = tx_active && !jabber_active;

    ////////////////////////////////////////////////////////////////////////
    // period timer for link pulses and bursts
    // leaving the off mode restarts it, so the first pulse follows at once
    logic [CNT_W-1:0] per_cnt_q;
    logic             per_tick;
    assign per_tick = (per_cnt_q == '0) && (link_mode != LPSUP_MODE_OFF);

    // a tick at count zero starts a pulse or a burst
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            per_cnt_q <= '0;
        end else if (link_mode == LPSUP_MODE_OFF) begin
            per_cnt_q <= '0;
        end else if (per_cnt_q == CNT_W'(PERIOD - 1)) begin
            per_cnt_q <= '0;
        end else begin
            per_cnt_q <= per_cnt_q + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // burst sequencer: clock slots with optional data pulse
    // the word is latched at burst start and shifted out one bit per slot
    logic                 burst_q;
    logic [IDX_W-1:0]     slot_q;
    logic [CNT_W-1:0]     slot_cnt_q;
    logic [WORD_BITS-1:0] word_q;
    logic                 fire;
    logic                 done_q;

    // slot counter wraps each clock spacing and moves to the next bit
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            burst_q    <= 1'b0;
            slot_q     <= '0;
            slot_cnt_q <= '0;
            word_q     <= '0;
            done_q     <= 1'b0;
        end else begin
            done_q <= 1'b0;
            // a tick in burst mode starts a burst unless one is still running
            if (per_tick && link_mode == LPSUP_MODE_BURST && !burst_q) begin
                burst_q    <= 1'b1;
                slot_q     <= '0;
                slot_cnt_q <= '0;
                word_q     <= burst_word;
            end else if (burst_q) begin
                if (slot_cnt_q == CNT_W'(CLK_SPACE - 1)) begin
                    slot_cnt_q <= '0;
                    word_q     <= word_q >> 1;
                    slot_q     <= slot_q + 1'b1;
                end else begin
                    slot_cnt_q <= slot_cnt_q + 1'b1;
                end
                // the burst ends one cycle before the last clock pulse falls, after 19 of its 20 cycles
                if (last_slot(slot_q) && slot_cnt_q == CNT_W'(PULSE_CYC - 1)) begin
                    burst_q <= 1'b0;
                    done_q  <= 1'b1;
                end
            end
        end
    end

    // pulse start decisions: clock slot start, data for a one bit, idle pulse
    // an idle pulse is held back while the MAC transmits
    always_comb begin
        fire = 1'b0;
        if (burst_q && slot_cnt_q == '0) begin
            fire = 1'b1;
        end
        // a one bit gives a data pulse mid slot; a zero bit leaves the slot empty
        if (burst_q && slot_cnt_q == CNT_W'(DATA_OFS) && word_q[0] && !last_slot(slot_q)) begin
            fire = 1'b1;
        end
        if (per_tick && link_mode == LPSUP_MODE_NLP && !tx_active) begin
            fire = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pulse width stretcher
    // a start while high reloads the width, so back to back pulses never shrink
    logic [PW_W-1:0] pw_cnt_q;
    logic            pulse_q;

    // width counts down from the reload value
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pw_cnt_q <= '0;
            pulse_q  <= 1'b0;
        end else if (fire) begin
            pulse_q  <= 1'b1;
            pw_cnt_q <= PW_W'(PULSE_CYC - 1);
        end else if (pw_cnt_q != '0) begin
            pw_cnt_q <= pw_cnt_q - 1'b1;
        end else begin
            // the pulse falls once the count has run out
            pulse_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // link bundle straight from flops
    // word_done flags the end of each burst for one cycle
    assign link_out.pulse        = pulse_q;
    assign link_out.burst_active = burst_q;
    assign link_out.word_done    = done_q;

endmodule

// ==== common/lpsup_pkg.sv ====
package lpsup_pkg;

    // clock rate
    localparam int CLK_PERIOD_PS = 5000;

    // heartbeat timing in ns
    localparam int HB_DELAY_NS  = 1200;
    localparam int HB_WIDTH_NS  = 1000;
    localparam int HB_DELAY_CYC = (HB_DELAY_NS * 1000) / CLK_PERIOD_PS;
    localparam int HB_WIDTH_CYC = (HB_WIDTH_NS * 1000) / CLK_PERIOD_PS;

    // jabber timing in ms
    localparam int JAB_ON_MS   = 85;
    localparam int JAB_OFF_MS  = 500;
    localparam int JAB_ON_CYC  = (JAB_ON_MS * 1000) * (1000000 / CLK_PERIOD_PS);
    localparam int JAB_OFF_CYC = (JAB_OFF_MS * 1000) * (1000000 / CLK_PERIOD_PS);

    // pulse widths in ns
    localparam int PULSE_NS  = 100;
    localparam int PULSE_CYC = (PULSE_NS * 1000) / CLK_PERIOD_PS;

    // normal link pulse and burst period in ms
    localparam int PERIOD_MS  = 16;
    localparam int PERIOD_CYC = (PERIOD_MS * 1000) * (1000000 / CLK_PERIOD_PS);

    // fast burst timing in us
    localparam int CLK_SPACE_US  = 125;
    localparam int DATA_OFS_US   = 62;
    localparam int CLK_SPACE_CYC = (CLK_SPACE_US * 1000000) / CLK_PERIOD_PS;
    localparam int DATA_OFS_CYC  = (DATA_OFS_US * 1000000) / CLK_PERIOD_PS;

    // burst length in ms, and the number of clock pulses that covers it
    localparam int BURST_MS      = 2;
    localparam int BURST_CYC     = (BURST_MS * 1000) * (1000000 / CLK_PERIOD_PS);
    localparam int BURST_CLOCKS  = BURST_CYC / CLK_SPACE_CYC + 1;
    localparam int WORD_BITS     = BURST_CLOCKS - 1;

    // wide counter width
    localparam int CNT_W = 28;

    // link modes
    typedef enum logic [1:0] {
        LPSUP_MODE_OFF,
        LPSUP_MODE_NLP,
        LPSUP_MODE_BURST
    } lpsup_mode_type;

    // link pulse output bundle
    typedef struct packed {
        logic pulse;
        logic burst_active;
        logic word_done;
    } lpsup_link_type;

endpackage

// ==== testbench/lpsup_core_sva.sv ====
`timescale 1ns/100ps
module lpsup_core_sva #(
    parameter int JAB_ON    = 50,
    parameter int JAB_OFF   = 80,
    parameter int PERIOD    = 2000,
    parameter int CLK_SPACE = 100
) (
    // clock and reset
    input wire logic                      core_clk,
    input wire logic                      reset_n,
    // watched ports
    input wire lpsup_pkg::lpsup_mode_type link_mode,
    input wire logic                      mode_10m,
    input wire logic                      tx_active,
    input wire lpsup_pkg::lpsup_link_type link_out,
    input wire logic                      collision_heartbeat,
    input wire logic                      jabber_active,
    input wire logic                      tx_gated
);
    import lpsup_pkg::*;
    logic [31:0] hb_q, pw_q, tx_q, jb_q, ba_q, bp_q;
    ////////////////////////////////////////
    // run lengths of levels, cycles since last burst start
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            {hb_q, pw_q, tx_q, jb_q, ba_q, bp_q} <= '0;
        end else begin
            hb_q <= collision_heartbeat ? hb_q + 32'h1 : '0;
            pw_q <= link_out.pulse ? pw_q + 32'h1 : '0;
            tx_q <= (tx_active && mode_10m && !jabber_active) ? tx_q + 32'h1 : '0;
            jb_q <= jabber_active ? jb_q + 32'h1 : '0;
            ba_q <= link_out.burst_active ? ba_q + 32'h1 : '0;
            bp_q <= (link_mode != LPSUP_MODE_BURST) ? '0 : (link_out.burst_active
                    && ba_q == '0) ? 32'h1 : (bp_q == '0) ? '0 : bp_q + 32'h1;
        end
    end
    ////////////////////////////////////////
    // timing relations
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    AST_HB_DELAY: assert property ($fell(tx_active) && mode_10m |->
        ##241 $rose(collision_heartbeat)) else $error("heartbeat delay wrong");
    AST_HB_WIDTH: assert property ($fell(collision_heartbeat) |->
        hb_q == HB_WIDTH_CYC) else $error("heartbeat width wrong");
    AST_PULSE_WIDTH: assert property ($fell(link_out.pulse) |->
        pw_q == PULSE_CYC) else $error("pulse width wrong");
    AST_JAB_ON: assert property ($rose(jabber_active) |->
        tx_q inside {[JAB_ON-1:JAB_ON+1]}) else $error("jabber on time wrong");
    AST_JAB_OFF: assert property ($fell(jabber_active) |->
        jb_q == JAB_OFF) else $error("jabber off time wrong");
    AST_GATE: assert property (tx_gated == (tx_active && !jabber_active))
        else $error("transmit gate wrong");
    AST_BURST_PERIOD: assert property ($rose(link_out.burst_active) && bp_q != '0 |->
        bp_q == PERIOD) else $error("burst period wrong");
    AST_BURST_WIDTH: assert property ($fell(link_out.burst_active) |->
        ba_q inside {[16*CLK_SPACE+18:16*CLK_SPACE+24]}) else $error("burst width wrong");
    cover property ($rose(collision_heartbeat));
    cover property ($fell(jabber_active));
    cover property (link_out.word_done);
endmodule
bind lpsup_core lpsup_core_sva #(.JAB_ON(JAB_ON), .JAB_OFF(JAB_OFF), .PERIOD(PERIOD),
    .CLK_SPACE(CLK_SPACE)) u_sva (.core_clk(core_clk), .reset_n(reset_n),
    .link_mode(link_mode), .mode_10m(mode_10m), .tx_active(tx_active),
    .link_out(link_out), .collision_heartbeat(collision_heartbeat),
    .jabber_active(jabber_active), .tx_gated(tx_gated));

// ==== testbench/lpsup_link_partner.sv ====
`timescale 1ns/100ps
module lpsup_link_partner #(
    parameter int CLK_SPACE = 100,
    parameter int DATA_OFS  = 50
) (
    // wire side
    input wire logic                      core_clk,
    input wire lpsup_pkg::lpsup_link_type link_out,
    // decoded traffic
    output logic [lpsup_pkg::WORD_BITS-1:0] rx_word,
    output int                            n_clk,
    output int                            n_bad,
    output int                            n_nlp
);
    import lpsup_pkg::*;
    logic p_q = 1'b0;
    logic b_q = 1'b0;
    int   gap = 0;
    // decode pulse positions against the last clock pulse
    initial {rx_word, n_clk, n_bad, n_nlp} = '0;
    always @(posedge core_clk) begin
        gap = gap + 1;
        if (link_out.burst_active && !b_q) begin
            {rx_word, n_clk, n_bad} = '0;
        end
        if (link_out.pulse && !p_q) begin
            if (!link_out.burst_active) n_nlp++;
            else if (n_clk > 0 && n_clk <= WORD_BITS && gap == DATA_OFS) rx_word[n_clk-1] = 1'b1;
            else begin
                if (n_clk > 0 && gap != CLK_SPACE) n_bad++;
                n_clk++;
                gap = 0;
            end
        end
        p_q = link_out.pulse;
        b_q = link_out.burst_active;
    end
endmodule

// ==== testbench/link_pulse_and_10m_supervision_tb_top.sv ====
`timescale 1ns/100ps
module link_pulse_and_10m_supervision_tb_top;
    import lpsup_pkg::*;
    localparam int PER  = 2000;
    localparam int JON  = 50;
    localparam int JOFF = 80;
    localparam int CSP  = 100;
    localparam int DOF  = 50;
    logic                 core_clk = 1'b0, reset_n = 1'b0, mode_10m = 1'b0, tx_active = 1'b0;
    lpsup_mode_type       link_mode = LPSUP_MODE_OFF;
    logic [WORD_BITS-1:0] burst_word = '0, rx_word;
    lpsup_link_type       link_out;
    logic                 collision_heartbeat, jabber_active, tx_gated;
    int                   n_clk, n_bad, n_nlp, error_cnt = 0, n_checks = 0, cyc = 0, k, i, w;
    ////////////////////////////////////////
    // design and far side
    lpsup_core #(.JAB_ON(JON), .JAB_OFF(JOFF), .PERIOD(PER), .CLK_SPACE(CSP), .DATA_OFS(DOF))
        u_dut (.core_clk(core_clk), .reset_n(reset_n), .link_mode(link_mode),
        .mode_10m(mode_10m), .tx_active(tx_active), .burst_word(burst_word),
        .link_out(link_out), .collision_heartbeat(collision_heartbeat),
        .jabber_active(jabber_active), .tx_gated(tx_gated));
    lpsup_link_partner #(.CLK_SPACE(CSP), .DATA_OFS(DOF)) u_far (.core_clk(core_clk),
        .link_out(link_out), .rx_word(rx_word), .n_clk(n_clk), .n_bad(n_bad), .n_nlp(n_nlp));
    // clock and hang guard
    always #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 40000) begin
            error_cnt++;
            finish_test();
        end
    end
    ////////////////////////////////////////
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    function automatic logic sel(int s);
        return s ? jabber_active : collision_heartbeat;
    endfunction
    // heartbeat length that an end of transmit should give
    function automatic int exp_hb(input logic m10);
        return m10 ? HB_WIDTH_CYC : 0;
    endfunction
    // length of the next high run of a level, 0 if none
    task automatic high_len(input int s, output int n);
        n = 0;
        for (k = 0; k < 400 && sel(s) !== 1'b1; k++) @(posedge core_clk) #1;
        while (sel(s) === 1'b1 && n < 400) begin
            n++;
            @(posedge core_clk) #1;
        end
    endtask
    task finish_test();
        if (error_cnt == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    ////////////////////////////////////////
    // heartbeat, jabber, idle pulses, bursts
    initial begin
        void'($urandom(58));
        repeat (20) @(posedge core_clk);
        reset_n <= 1'b1;
        for (i = 0; i < 4; i++) begin
            @(posedge core_clk) mode_10m <= (i < 2);
            tx_active <= 1'b1;
            repeat (5 + $urandom % 40) @(posedge core_clk);
            tx_active <= 1'b0;
            high_len(0, w);
            chk("heartbeat_len", exp_hb(i < 2), w);
        end
        @(posedge core_clk) mode_10m <= 1'b1;
        tx_active <= 1'b1;
        high_len(1, w);
        chk("jabber_len", JOFF, w);
        @(posedge core_clk) tx_active <= 1'b0;
        repeat (600) @(posedge core_clk);
        link_mode <= LPSUP_MODE_NLP;
        w = n_nlp;
        repeat (3 * PER + 100) @(posedge core_clk);
        chk("idle_pulses", 4, n_nlp - w);
        link_mode <= LPSUP_MODE_OFF;
        for (i = 0; i < 5; i++) begin
            @(posedge core_clk) burst_word <= (i == 0) ? '0 : (i == 1) ? '1 : WORD_BITS'($urandom);
            link_mode <= LPSUP_MODE_BURST;
            for (k = 0; k < 2 * PER && link_out.word_done !== 1'b1; k++) @(posedge core_clk) #1;
            chk("burst_word", burst_word, rx_word);
            chk("clock_pulses", WORD_BITS + 1, n_clk);
            chk("clock_spacing", 0, n_bad);
        end
        finish_test();
    end
endmodule
